// ---- dac_host_pkg.sv ----
/*
 Constants, field layouts and carrier types shared by the DAC host port controller.
 Assumes a 25 MHz aclk and a write-only, double-buffered 14-bit DAC on an 8-bit pin bus.
*/
package dac_host_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_SETUP_NS = 80;
  localparam int T_STROBE_NS = 100;
  localparam int T_HOLD_NS = 40;

  function automatic int ns_to_min_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_min_cycles

  localparam int SETUP_CYC = ns_to_min_cycles(T_SETUP_NS);
  localparam int STROBE_CYC = ns_to_min_cycles(T_STROBE_NS);
  localparam int HOLD_CYC = ns_to_min_cycles(T_HOLD_NS);
  localparam int CNT_W = 4;

  // ==========================================================================
  // Device side
  localparam int CODE_W = 14;
  localparam int HIGH_W = 6;
  localparam int LOW_W = 8;
  localparam int DATA_W = 8;
  localparam logic [1:0] LOC_CAL = 2'h0;
  localparam logic [1:0] LOC_HIGH = 2'h1;
  localparam logic [1:0] LOC_LOW = 2'h2;
  localparam logic [1:0] LOC_XFER = 2'h3;
  localparam logic [7:0] CAL_ZERO_DATA = 8'h00;
  localparam logic [7:0] CAL_ONE_DATA = 8'hff;
  localparam logic [7:0] XFER_DATA = 8'h00;
  localparam logic [CODE_W-1:0] CODE_ZERO = 14'h0000;
  localparam logic [CODE_W-1:0] CODE_ONES = 14'h3fff;

  // ==========================================================================
  // Controller registers (AXI4-Lite byte offsets)
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CODE = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CMD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] REG_LAST = 4'hc;
  localparam logic [2:0] CMD_LOAD = 3'h1;
  localparam logic [2:0] CMD_HIGH = 3'h2;
  localparam logic [2:0] CMD_LOW = 3'h3;
  localparam logic [2:0] CMD_XFER = 3'h4;
  localparam logic [2:0] CMD_CAL_ZERO = 3'h5;
  localparam logic [2:0] CMD_CAL_ONE = 3'h6;
  localparam int ST_BUSY = 0;
  localparam int ST_DROP = 1;
  localparam int PEND_HIGH = 0;
  localparam int PEND_LOW = 1;
  localparam int PEND_XFER = 2;
  localparam int PEND_CAL = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic location_select_high;
    logic location_select_low;
    logic [DATA_W-1:0] host_low_byte_lanes;
  } dac_pins_t;

  typedef struct packed {
    logic [1:0] loc;
    logic [DATA_W-1:0] data;
  } pin_req_t;

  localparam dac_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h00};

endpackage : dac_host_pkg

// ---- dac_pin_writer.sv ----
/*
 One DAC bus write cycle: chip select, location and data set up, write strobe, hold.
 Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/10ps
module dac_pin_writer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request
  input wire logic start,
  input dac_host_pkg::pin_req_t req,
  output logic busy,
  // DAC pins
  output dac_host_pkg::dac_pins_t pins
);

  typedef enum logic [1:0] {
    W_IDLE = 2'h0,
    W_SETUP = 2'h1,
    W_STROBE = 2'h3,
    W_HOLD = 2'h2
  } wr_state_t;

  wr_state_t state_q;
  logic [dac_host_pkg::CNT_W-1:0] cnt_q;

  assign busy = (state_q != W_IDLE);

  // ==========================================================================
  // Phase sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= W_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        W_IDLE: begin
          if (start) begin
            state_q <= W_SETUP;
            cnt_q <= dac_host_pkg::CNT_W'(dac_host_pkg::SETUP_CYC - 1);
          end
        end
        W_SETUP: begin
          if (cnt_q == '0) begin
            state_q <= W_STROBE;
            cnt_q <= dac_host_pkg::CNT_W'(dac_host_pkg::STROBE_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        W_STROBE: begin
          if (cnt_q == '0) begin
            state_q <= W_HOLD;
            cnt_q <= dac_host_pkg::CNT_W'(dac_host_pkg::HOLD_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        W_HOLD: begin
          if (cnt_q == '0) begin
            state_q <= W_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= W_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pin drive: select and data stay put for the whole cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins <= dac_host_pkg::PINS_IDLE;
    end else begin
      case (state_q)
        W_IDLE: begin
          if (start) begin
            pins.cs_n <= 1'b0;
            pins.location_select_high <= req.loc[1];
            pins.location_select_low <= req.loc[0];
            pins.host_low_byte_lanes <= req.data;
          end
        end
        W_SETUP: begin
          if (cnt_q == '0) begin
            pins.wr_n <= 1'b0;
          end
        end
        W_STROBE: begin
          if (cnt_q == '0) begin
            pins.wr_n <= 1'b1;
          end
        end
        W_HOLD: begin
          if (cnt_q == '0) begin
            pins.cs_n <= 1'b1;
          end
        end
        default: begin
          pins <= dac_host_pkg::PINS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Checks
  property p_data_stable_strobe;
    @(posedge aclk) disable iff (!aresetn)
      (!pins.cs_n && $past(!pins.cs_n)) |-> $stable(pins.host_low_byte_lanes);
  endproperty
  a_data_stable_strobe: assert property (p_data_stable_strobe)
    else $error("data lanes changed while chip select low");

  property p_strobe_inside_select;
    @(posedge aclk) disable iff (!aresetn)
      $fell(pins.wr_n) |-> !pins.cs_n && $past(!pins.cs_n) ##1 !pins.wr_n;
  endproperty
  a_strobe_inside_select: assert property (p_strobe_inside_select)
    else $error("write strobe not framed by chip select");

  property p_start_to_select;
    @(posedge aclk) disable iff (!aresetn)
      (start && !busy) |=> !pins.cs_n && pins.wr_n && busy;
  endproperty
  a_start_to_select: assert property (p_start_to_select)
    else $error("chip select did not follow start");

endmodule : dac_pin_writer

// ---- dac_host_port.sv ----
/*
 AXI4-Lite controlled host port for a double-buffered 14-bit DAC on an 8-bit write bus.
 Assumes an AXI4-Lite master with one write and one read outstanding, and a write-only DAC.
*/
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module dac_host_port (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [dac_host_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [dac_host_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // DAC pins
  output dac_host_pkg::dac_pins_t dac_pins
);

  logic aw_have_q;
  logic w_have_q;
  logic [dac_host_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [dac_host_pkg::CODE_W-1:0] code_q;
  logic [dac_host_pkg::CODE_W-1:0] snap_q;
  logic [dac_host_pkg::HIGH_W-1:0] hi_q;
  logic [dac_host_pkg::LOW_W-1:0] lo_q;
  logic [dac_host_pkg::CODE_W-1:0] last_q;
  logic [3:0] pend_q;
  logic cal_one_q;
  logic drop_q;
  logic start_q;
  dac_host_pkg::pin_req_t req_q;
  logic wr_busy;
  logic busy_any;
  logic cmd_hit;

  assign do_write = aw_have_q && w_have_q && !s_bvalid;
  assign busy_any = (pend_q != '0) || wr_busy || start_q;
  assign cmd_hit = do_write && (awaddr_q == dac_host_pkg::REG_CMD) && wstrb_q[0];

  // ==========================================================================
  // AXI4-Lite write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_bvalid <= 1'b0;
      s_bresp <= dac_host_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_bvalid <= 1'b1;
        case (awaddr_q)
          dac_host_pkg::REG_CODE, dac_host_pkg::REG_CMD,
          dac_host_pkg::REG_STATUS, dac_host_pkg::REG_LAST: begin
            s_bresp <= dac_host_pkg::RESP_OKAY;
          end
          default: begin
            s_bresp <= dac_host_pkg::RESP_SLVERR;
          end
        endcase
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Code register with byte lanes; every 14-bit value is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_q <= dac_host_pkg::CODE_ZERO;
    end else if (do_write && awaddr_q == dac_host_pkg::REG_CODE) begin
      if (wstrb_q[0]) begin
        code_q[dac_host_pkg::LOW_W-1:0] <= wdata_q[dac_host_pkg::LOW_W-1:0];
      end
      if (wstrb_q[1]) begin
        code_q[dac_host_pkg::CODE_W-1:dac_host_pkg::LOW_W] <=
          wdata_q[dac_host_pkg::CODE_W-1:dac_host_pkg::LOW_W];
      end
    end
  end

  // ==========================================================================
  // Dropped-command flag: a new drop beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_q <= 1'b0;
    end else if (cmd_hit && busy_any) begin
      drop_q <= 1'b1;
    end else if (do_write && awaddr_q == dac_host_pkg::REG_STATUS && wstrb_q[0] &&
                 wdata_q[dac_host_pkg::ST_DROP]) begin
      drop_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Command planning and write sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= '0;
      snap_q <= dac_host_pkg::CODE_ZERO;
      cal_one_q <= 1'b0;
      start_q <= 1'b0;
      req_q <= '0;
      hi_q <= '0;
      lo_q <= '0;
      last_q <= dac_host_pkg::CODE_ZERO;
    end else begin
      start_q <= 1'b0;
      if (cmd_hit && !busy_any) begin
        snap_q <= code_q;
        case (wdata_q[2:0])
          dac_host_pkg::CMD_LOAD: pend_q <= 4'h7;
          dac_host_pkg::CMD_HIGH: pend_q <= 4'h1;
          dac_host_pkg::CMD_LOW: pend_q <= 4'h2;
          dac_host_pkg::CMD_XFER: pend_q <= 4'h4;
          dac_host_pkg::CMD_CAL_ZERO: begin
            pend_q <= 4'h8;
            cal_one_q <= 1'b0;
          end
          dac_host_pkg::CMD_CAL_ONE: begin
            pend_q <= 4'h8;
            cal_one_q <= 1'b1;
          end
          default: pend_q <= '0;
        endcase
      end else if (!wr_busy && !start_q && pend_q != '0) begin
        start_q <= 1'b1;
        if (pend_q[dac_host_pkg::PEND_HIGH]) begin
          pend_q[dac_host_pkg::PEND_HIGH] <= 1'b0;
          req_q <= '{dac_host_pkg::LOC_HIGH,
                     {2'h0, snap_q[dac_host_pkg::CODE_W-1:dac_host_pkg::LOW_W]}};
          hi_q <= snap_q[dac_host_pkg::CODE_W-1:dac_host_pkg::LOW_W];
        end else if (pend_q[dac_host_pkg::PEND_LOW]) begin
          pend_q[dac_host_pkg::PEND_LOW] <= 1'b0;
          req_q <= '{dac_host_pkg::LOC_LOW, snap_q[dac_host_pkg::LOW_W-1:0]};
          lo_q <= snap_q[dac_host_pkg::LOW_W-1:0];
        end else if (pend_q[dac_host_pkg::PEND_XFER]) begin
          pend_q[dac_host_pkg::PEND_XFER] <= 1'b0;
          req_q <= '{dac_host_pkg::LOC_XFER, dac_host_pkg::XFER_DATA};
          last_q <= {hi_q, lo_q};
        end else begin
          pend_q[dac_host_pkg::PEND_CAL] <= 1'b0;
          req_q <= '{dac_host_pkg::LOC_CAL, cal_one_q ? dac_host_pkg::CAL_ONE_DATA :
                                                        dac_host_pkg::CAL_ZERO_DATA};
          last_q <= cal_one_q ? dac_host_pkg::CODE_ONES : dac_host_pkg::CODE_ZERO;
        end
      end
    end
  end

  dac_pin_writer u_writer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_q),
    .req(req_q),
    .busy(wr_busy),
    .pins(dac_pins)
  );

  // ==========================================================================
  // AXI4-Lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= dac_host_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= dac_host_pkg::RESP_OKAY;
      case (s_araddr)
        dac_host_pkg::REG_CODE: s_rdata <= {18'h0, code_q};
        dac_host_pkg::REG_CMD: s_rdata <= '0;
        dac_host_pkg::REG_STATUS: s_rdata <= {30'h0, drop_q, busy_any};
        dac_host_pkg::REG_LAST: s_rdata <= {18'h0, last_q};
        default: begin
          s_rdata <= '0;
          s_rresp <= dac_host_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  property p_high_before_low;
    @(posedge aclk) disable iff (!aresetn)
      (start_q && req_q.loc == dac_host_pkg::LOC_LOW) |-> !pend_q[dac_host_pkg::PEND_HIGH];
  endproperty
  a_high_before_low: assert property (p_high_before_low)
    else $error("low byte issued before pending high byte");

  property p_xfer_after_bytes;
    @(posedge aclk) disable iff (!aresetn)
      (start_q && req_q.loc == dac_host_pkg::LOC_XFER) |->
        pend_q[dac_host_pkg::PEND_LOW:dac_host_pkg::PEND_HIGH] == 2'h0 &&
        last_q == {hi_q, lo_q};
  endproperty
  a_xfer_after_bytes: assert property (p_xfer_after_bytes)
    else $error("transfer issued before both bytes");

  property p_high_byte_lanes;
    @(posedge aclk) disable iff (!aresetn)
      (start_q && req_q.loc == dac_host_pkg::LOC_HIGH) |->
        req_q.data[7:6] == 2'h0 ##1 dac_pins.host_low_byte_lanes == $past(req_q.data);
  endproperty
  a_high_byte_lanes: assert property (p_high_byte_lanes)
    else $error("high byte not right-justified on pins");

  property p_normal_locations;
    @(posedge aclk) disable iff (!aresetn)
      (start_q && req_q.loc == dac_host_pkg::LOC_CAL) |->
        pend_q[dac_host_pkg::PEND_XFER:dac_host_pkg::PEND_HIGH] == 3'h0 &&
        ((req_q.data == dac_host_pkg::CAL_ONE_DATA && last_q == dac_host_pkg::CODE_ONES) ||
         (req_q.data == dac_host_pkg::CAL_ZERO_DATA && last_q == dac_host_pkg::CODE_ZERO));
  endproperty
  a_normal_locations: assert property (p_normal_locations)
    else $error("fourth location used outside calibration");

  property p_load_busy;
    @(posedge aclk) disable iff (!aresetn)
      (cmd_hit && !busy_any && wdata_q[2:0] == dac_host_pkg::CMD_LOAD) |=>
        busy_any ##[1:4] start_q;
  endproperty
  a_load_busy: assert property (p_load_busy)
    else $error("accepted load did not start a pin write");

  c_full_load: cover property (@(posedge aclk) disable iff (!aresetn)
    start_q && req_q.loc == dac_host_pkg::LOC_XFER);
  c_cal_write: cover property (@(posedge aclk) disable iff (!aresetn)
    start_q && req_q.loc == dac_host_pkg::LOC_CAL);
  c_drop: cover property (@(posedge aclk) disable iff (!aresetn)
    cmd_hit && busy_any);

endmodule : dac_host_port

// ---- dac_device_model.sv ----
/*
 Behavioural model of the write-only, double-buffered 14-bit DAC at the pin bus.
 Assumes the pins come from flops on aclk; aclk is used only to sample them.
*/
`timescale 1ns/10ps
module dac_device_model (
  // Sampling clock
  input wire logic aclk,
  // Pin bus, data on the eight low lanes only
  input wire dac_host_pkg::dac_pins_t pins,
  // Observed state
  output logic [5:0] high_q,
  output logic [7:0] low_q,
  output logic [13:0] dac_q,
  output logic [5:0] loc_trail,
  output int n_writes,
  output int n_bad
);
  dac_host_pkg::dac_pins_t prev = dac_host_pkg::PINS_IDLE;
  logic [1:0] loc;
  logic [7:0] dat;

  initial begin
    high_q = 6'h00;
    low_q = 8'h00;
    dac_q = 14'h0000;
    loc_trail = 6'h00;
    n_writes = 0;
    n_bad = 0;
  end

  // ==========================================================================
  // Write decode: a write completes on the strobe's rising edge
  always @(posedge aclk) begin
    loc = {pins.location_select_high, pins.location_select_low};
    dat = pins.host_low_byte_lanes;
    if (!prev.cs_n && !pins.cs_n && prev[9:0] !== pins[9:0]) begin
      n_bad++;
    end
    if (!pins.wr_n && pins.cs_n) begin
      n_bad++;
    end
    if (!prev.wr_n && pins.wr_n && !pins.cs_n) begin
      n_writes++;
      loc_trail = {loc_trail[3:0], loc};
      case (loc)
        dac_host_pkg::LOC_HIGH: high_q = dat[5:0];
        dac_host_pkg::LOC_LOW: low_q = dat;
        dac_host_pkg::LOC_XFER: dac_q = {high_q, low_q};
        default: begin
          dac_q = (dat == 8'hff) ? 14'h3fff : 14'h0000;
          if (dat != 8'hff && dat != 8'h00) n_bad++;
        end
      endcase
    end
    prev = pins;
  end
endmodule : dac_device_model

// ---- dac_host_port_tb.sv ----
/*
 Self-checking bench for the DAC host port: AXI4-Lite master tasks and scenarios.
 Assumes the device model above sits on the pin bus.
*/
`timescale 1ns/10ps
module dac_host_port_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  dac_host_pkg::dac_pins_t pins;
  logic [5:0] high_q, trail;
  logic [7:0] low_q;
  logic [13:0] dac_q;
  int n_writes, n_bad;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [13:0] codes [4] = '{14'h0000, 14'h3fff, 14'h2a5c, 14'h15a3};

  always #20 aclk = ~aclk;

  dac_host_port i_dac_host_port (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .dac_pins(pins));

  dac_device_model i_dac_device_model (.aclk(aclk), .pins(pins), .high_q(high_q),
    .low_q(low_q), .dac_q(dac_q), .loc_trail(trail), .n_writes(n_writes), .n_bad(n_bad));

  // ==========================================================================
  // Support tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h1;
    while (d[0] !== 1'b0) rd(dac_host_pkg::REG_STATUS, d, r);
  endtask : wait_idle

  task automatic send(input logic [13:0] c, input logic [2:0] cmd);
    logic [1:0] r;
    wr(dac_host_pkg::REG_CODE, {18'h0, c}, 4'h3, r);
    check("code bresp", 32'(r), 32'(dac_host_pkg::RESP_OKAY));
    wr(dac_host_pkg::REG_CMD, {29'h0, cmd}, 4'h1, r);
    check("cmd bresp", 32'(r), 32'(dac_host_pkg::RESP_OKAY));
    wait_idle();
  endtask : send

  // ==========================================================================
  // Scenarios
  task automatic t_load();
    logic [31:0] d;
    logic [1:0] r;
    int w;
    for (int i = 0; i < 4; i++) begin
      w = n_writes;
      send(codes[i], dac_host_pkg::CMD_LOAD);
      check("dac", 32'(dac_q), 32'(codes[i]));
      check("high", 32'(high_q), 32'(codes[i][13:8]));
      check("low", 32'(low_q), 32'(codes[i][7:0]));
      check("order", 32'(trail), 32'h1b);
      check("writes", 32'(n_writes - w), 32'd3);
      rd(dac_host_pkg::REG_LAST, d, r);
      check("last", d, 32'(codes[i]));
    end
    $display("load test done");
  endtask : t_load

  task automatic t_buffers();
    send(14'h3e00, dac_host_pkg::CMD_HIGH);
    check("high only", 32'(high_q), 32'h3e);
    check("dac kept", 32'(dac_q), 32'(codes[3]));
    send(14'h0011, dac_host_pkg::CMD_LOW);
    check("low only", 32'(low_q), 32'h11);
    check("dac kept", 32'(dac_q), 32'(codes[3]));
    send(14'h0000, dac_host_pkg::CMD_XFER);
    check("xfer", 32'(dac_q), 32'h3e11);
    check("xfer order", 32'(trail), 32'h1b);
    $display("buffer test done");
  endtask : t_buffers

  task automatic t_cal();
    logic [31:0] d;
    logic [1:0] r;
    send(14'h1234, dac_host_pkg::CMD_CAL_ONE);
    check("cal ones", 32'(dac_q), 32'h3fff);
    rd(dac_host_pkg::REG_LAST, d, r);
    check("last ones", d, 32'h3fff);
    send(14'h1234, dac_host_pkg::CMD_CAL_ZERO);
    check("cal zeros", 32'(dac_q), 32'h0);
    check("cal loc", 32'(trail[1:0]), 32'(dac_host_pkg::LOC_CAL));
    $display("calibration test done");
  endtask : t_cal

  task automatic t_drop_and_bad();
    logic [31:0] d;
    logic [1:0] r;
    int w;
    w = n_writes;
    wr(dac_host_pkg::REG_CODE, 32'h0abc, 4'h3, r);
    wr(dac_host_pkg::REG_CMD, 32'h1, 4'h1, r);
    wr(dac_host_pkg::REG_CMD, 32'h5, 4'h1, r);
    wait_idle();
    rd(dac_host_pkg::REG_STATUS, d, r);
    check("dropped", d, 32'h2);
    check("one load", 32'(n_writes - w), 32'd3);
    check("dac 0abc", 32'(dac_q), 32'h0abc);
    wr(dac_host_pkg::REG_STATUS, 32'h2, 4'h1, r);
    rd(dac_host_pkg::REG_STATUS, d, r);
    check("cleared", d, 32'h0);
    wr(4'h2, 32'h1, 4'hf, r);
    check("bad bresp", 32'(r), 32'(dac_host_pkg::RESP_SLVERR));
    rd(4'h2, d, r);
    check("bad rresp", 32'(r), 32'(dac_host_pkg::RESP_SLVERR));
    check("bad rdata", d, 32'h0);
    send(14'h0001, 3'h7);
    rd(dac_host_pkg::REG_CMD, d, r);
    check("cmd reads 0", d, 32'h0);
    check("no stray", 32'(n_writes - w), 32'd3);
    check("pin rules", 32'(n_bad), 32'd0);
    $display("refusal test done");
  endtask : t_drop_and_bad

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    check("idle pins", 32'(pins), 32'(dac_host_pkg::PINS_IDLE));
    @(posedge aclk);
    t_load();
    t_buffers();
    t_cal();
    t_drop_and_bad();
    print_verdict();
  end
endmodule : dac_host_port_tb
